// ---- core/cep_pkg.sv ----
// constants, error table and object layout of the emergency producer
package cep_pkg;

  localparam logic [15:0] IDX_ERR_REG    = 16'h1001;
  localparam logic [15:0] IDX_ERR_HIST   = 16'h1003;
  localparam logic [15:0] IDX_EMCY_ID    = 16'h1014;

  localparam int          COBID_OFF_BIT  = 31;
  localparam int          COBID_RSVD_BIT = 30;
  localparam int          COBID_EXT_BIT  = 29;
  localparam int          COBID_HI_MSB   = 28;
  localparam int          COBID_HI_LSB   = 11;
  localparam int          NODE_W         = 7;

  localparam logic [3:0]  EMCY_FUNC_CODE = 4'h1;
  localparam logic [10:0] TPDO1_BASE     = 11'h180;
  localparam logic [10:0] TPDO5_BASE     = 11'h184;
  localparam logic [3:0]  TPDO1_DLC      = 4'h2;
  localparam logic [3:0]  TPDO5_DLC      = 4'h4;
  localparam logic [3:0]  EMCY_DLC       = 4'h8;

  localparam int          HIST_DEPTH     = 5;
  localparam logic [2:0]  HIST_MAX       = 3'h5;
  localparam logic [7:0]  ERR_REG_MASK   = 8'h91;
  localparam logic [1:0]  INIT_WAIT      = 2'h3;

  localparam int          FRAME_W        = 98;
  localparam int          FIFO_DEPTH     = 4;

  typedef enum logic [3:0] {
    CEP_ERR_RESET    = 4'h0,
    CEP_ERR_CAN_CTRL = 4'h1,
    CEP_ERR_NVM      = 4'h2,
    CEP_ERR_SERIAL   = 4'h3,
    CEP_ERR_RX_OVR   = 4'h4,
    CEP_ERR_TX_OVR   = 4'h5,
    CEP_ERR_CAN_OVR  = 4'h6,
    CEP_ERR_LIFE     = 4'h7,
    CEP_ERR_BUSOFF   = 4'h8,
    CEP_ERR_PDO_LEN  = 4'h9,
    CEP_ERR_RST_REQ  = 4'hA
  } cep_err_e;

  // emergency error code, high byte in [15:8]
  function automatic logic [15:0] cep_emcy_code(input logic [3:0] kind);
    case (kind)
      CEP_ERR_CAN_CTRL:                 cep_emcy_code = 16'h1000;
      CEP_ERR_NVM, CEP_ERR_SERIAL:      cep_emcy_code = 16'h5000;
      CEP_ERR_RX_OVR, CEP_ERR_TX_OVR,
      CEP_ERR_CAN_OVR:                  cep_emcy_code = 16'h8110;
      CEP_ERR_LIFE:                     cep_emcy_code = 16'h8130;
      CEP_ERR_BUSOFF:                   cep_emcy_code = 16'h8140;
      CEP_ERR_PDO_LEN:                  cep_emcy_code = 16'h8210;
      CEP_ERR_RST_REQ:                  cep_emcy_code = 16'hFF00;
      default:                          cep_emcy_code = 16'h0000;
    endcase
  endfunction : cep_emcy_code

  function automatic logic [7:0] cep_emcy_reg(input logic [3:0] kind);
    case (kind)
      CEP_ERR_CAN_CTRL, CEP_ERR_NVM,
      CEP_ERR_SERIAL:                   cep_emcy_reg = 8'h81;
      CEP_ERR_RX_OVR, CEP_ERR_TX_OVR, CEP_ERR_CAN_OVR, CEP_ERR_LIFE,
      CEP_ERR_BUSOFF, CEP_ERR_PDO_LEN:  cep_emcy_reg = 8'h11;
      CEP_ERR_RST_REQ:                  cep_emcy_reg = 8'h80;
      default:                          cep_emcy_reg = 8'h00;
    endcase
  endfunction : cep_emcy_reg

  // first manufacturer byte equals the kind code for 1..10
  function automatic logic [7:0] cep_emcy_mfr(input logic [3:0] kind);
    cep_emcy_mfr = (kind <= CEP_ERR_RST_REQ) ? {4'h0, kind} : 8'h00;
  endfunction : cep_emcy_mfr

endpackage : cep_pkg

// ---- core/cep_fifo.sv ----
// small frame fifo with registered output stage
`timescale 1ns/1ps
`default_nettype none
module cep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;
  logic             load_out;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign load_out  = !out_valid || out_ready;
  assign pop       = load_out && (cnt_ff != '0);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load_out) begin
      out_valid <= (cnt_ff != '0);
      if (cnt_ff != '0) begin
        out_data <= mem[rd_ptr_ff];
      end
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_ff <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule : cep_fifo
`default_nettype wire

// ---- core/cep_emcy_producer.sv ----
// emergency producer with error history and input-change transmit pdos
//
// Summary of operation
// - Identifier bit 31 low means emergency valid, high means absent.
// - Bit 29 picks base or extended identifier; bit 30 reads zero.
// - Bits 10..0 low id; bits 28..11 upper id, zero in base format.
// - Identifier word lives at object emergency_identifier, writable or left default.
// - Default identifier is function code 0001 followed by 7-bit node id.
// - Every internal error taken while err_busy is low sends an emergency frame on the identifier when bit 31 is low.
// - Each emergency is recorded in history object error_history_list, five deep.
// - History sub-index 1 is newest, sub-index 5 oldest kept.
// - Payload: bytes 0-1 error code, byte 2 error register, 3-7 vendor.
// - Error register uses bits 0, 4, 7 only; bit 6 always zero.
// - Error reset frame carries all-zero code, register and vendor bytes.
// - Controller error: code 1000, register 81, vendor byte 01.
// - Memory or serial access: code 5000, register 81, vendor 02 or 03.
// - Overruns: code 8110, register 11, vendor 04, 05 or 06.
// - Life guarding 8130 vendor 07; bus-off recovery 8140 vendor 08; reg 11.
// - Pdo length mismatch: code 8210, register 11, vendor byte 09.
// - Reset request: code FF00, register 80, vendor byte 0A.
// - Produced frame's error register copied into object error_register_mirror.
// - Digital input change sends every transmit pdo mapping them.
// - Sixteen-bit values packed into payload low byte first.
`timescale 1ns/1ps
`default_nettype none
module cep_emcy_producer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [6:0]  node_id,
  input  wire logic [15:0] digital_input_word,
  input  wire logic [15:0] analog_input_channel,
  input  wire logic        err_valid,
  input  wire logic [3:0]  err_kind,
  output var  logic        err_busy,
  input  wire logic        obj_req,
  input  wire logic        obj_we,
  input  wire logic [15:0] obj_index,
  input  wire logic [7:0]  obj_subindex,
  input  wire logic [31:0] obj_wdata,
  output var  logic        obj_ack,
  output var  logic        obj_abort,
  output var  logic [31:0] obj_rdata,
  output var  logic        tx_valid,
  input  wire logic        tx_ready,
  output var  logic        tx_ext,
  output var  logic [28:0] tx_id,
  output var  logic [3:0]  tx_dlc,
  output var  logic [63:0] tx_data
);
  localparam int FW = cep_pkg::FRAME_W;

  // pin synchronisers
  logic [38:0]  pin_s1_ff;
  logic [38:0]  pin_s2_ff;
  logic [6:0]   node_s;
  logic [15:0]  di_s;
  logic [15:0]  ai_s;
  logic [15:0]  di_prev_ff;
  logic         di_change;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= {node_id, digital_input_word, analog_input_channel};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  assign node_s = pin_s2_ff[38:32];
  assign di_s   = pin_s2_ff[31:16];
  assign ai_s   = pin_s2_ff[15:0];

  // startup: node id settles through the synchroniser first
  logic [1:0]  init_cnt_ff;
  logic        init_done_ff;
  logic [31:0] cob_id_ff;
  logic [31:0] default_id;

  assign default_id = {21'h000000, cep_pkg::EMCY_FUNC_CODE, node_s};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_ff  <= '0;
      init_done_ff <= 1'b0;
    end else if (!init_done_ff) begin
      init_cnt_ff  <= init_cnt_ff + 2'h1;
      init_done_ff <= (init_cnt_ff == cep_pkg::INIT_WAIT);
    end
  end

  // object access decode
  logic        acc_id;
  logic        acc_reg;
  logic        acc_hist;
  logic        id_wr_ok;
  logic        hist_clr;
  logic [31:0] wr_id;

  assign acc_id   = obj_index == cep_pkg::IDX_EMCY_ID && obj_subindex == 8'h00;
  assign acc_reg  = obj_index == cep_pkg::IDX_ERR_REG && obj_subindex == 8'h00;
  assign acc_hist = obj_index == cep_pkg::IDX_ERR_HIST &&
                    obj_subindex <= 8'(cep_pkg::HIST_DEPTH);
  // base format with upper bits set is refused
  assign id_wr_ok = obj_wdata[cep_pkg::COBID_EXT_BIT] ||
                    obj_wdata[cep_pkg::COBID_HI_MSB:cep_pkg::COBID_HI_LSB]
                      == '0;
  assign wr_id    = obj_wdata & ~(32'h1 << cep_pkg::COBID_RSVD_BIT);
  assign hist_clr = obj_req && obj_we && acc_hist && obj_subindex == 8'h00 &&
                    obj_wdata == 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cob_id_ff <= 32'h0;
    end else if (!init_done_ff && init_cnt_ff == cep_pkg::INIT_WAIT) begin
      cob_id_ff <= default_id;
    end else if (obj_req && obj_we && acc_id && id_wr_ok && init_done_ff) begin
      cob_id_ff <= wr_id;
    end
  end

  // pending emergency event
  logic       emcy_pend_ff;
  logic [3:0] emcy_kind_ff;
  logic       emcy_commit;
  logic       emcy_off;

  assign emcy_off = cob_id_ff[cep_pkg::COBID_OFF_BIT];
  assign err_busy = emcy_pend_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      emcy_pend_ff <= 1'b0;
      emcy_kind_ff <= 4'h0;
    end else if (err_valid && !emcy_pend_ff) begin
      emcy_pend_ff <= 1'b1;
      emcy_kind_ff <= err_kind;
    end else if (emcy_commit) begin
      emcy_pend_ff <= 1'b0;
    end
  end

  // transmit pdo requests on digital input change
  logic tp1_pend_ff;
  logic tp5_pend_ff;
  logic sel_tp1;
  logic sel_tp5;

  assign di_change = init_done_ff && (di_s != di_prev_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      di_prev_ff <= 16'h0;
    end else if (init_done_ff) begin
      di_prev_ff <= di_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tp1_pend_ff <= 1'b0;
      tp5_pend_ff <= 1'b0;
    end else begin
      tp1_pend_ff <= di_change || (tp1_pend_ff && !sel_tp1);
      tp5_pend_ff <= di_change || (tp5_pend_ff && !sel_tp5);
    end
  end

  // frame assembly and arbitration, emergency first
  logic          fifo_ready;
  logic          fifo_push;
  logic [FW-1:0] push_frame;
  logic [15:0]   ev_code;
  logic [7:0]    ev_reg;
  logic [7:0]    ev_mfr;
  logic [63:0]   emcy_payload;
  logic [10:0]   node_ext;

  assign ev_code  = cep_pkg::cep_emcy_code(emcy_kind_ff);
  assign ev_reg   = cep_pkg::cep_emcy_reg(emcy_kind_ff) &
                    cep_pkg::ERR_REG_MASK;
  assign ev_mfr   = cep_pkg::cep_emcy_mfr(emcy_kind_ff);
  // byte 0 carries the low half of the error code
  assign emcy_payload = {32'h0, ev_mfr, ev_reg, ev_code[15:8],
                         ev_code[7:0]};
  assign node_ext = {4'h0, node_s};

  // suppressed emergency still commits, but pushes nothing
  assign emcy_commit = init_done_ff && emcy_pend_ff &&
                       (emcy_off || fifo_ready);
  assign sel_tp1 = init_done_ff && fifo_ready && tp1_pend_ff && !emcy_pend_ff;
  assign sel_tp5 = init_done_ff && fifo_ready && tp5_pend_ff && !emcy_pend_ff
                   && !tp1_pend_ff;
  assign fifo_push = (emcy_commit && !emcy_off) || sel_tp1 || sel_tp5;

  always_comb begin
    push_frame = '0;
    if (emcy_pend_ff) begin
      push_frame = {cob_id_ff[cep_pkg::COBID_EXT_BIT], cob_id_ff[28:0],
                    cep_pkg::EMCY_DLC, emcy_payload};
    end else if (tp1_pend_ff) begin
      push_frame = {1'b0, 18'h0, cep_pkg::TPDO1_BASE + node_ext,
                    cep_pkg::TPDO1_DLC, 48'h0, di_s[15:8], di_s[7:0]};
    end else begin
      push_frame = {1'b0, 18'h0, cep_pkg::TPDO5_BASE + node_ext,
                    cep_pkg::TPDO5_DLC, 32'h0, ai_s[15:8], ai_s[7:0],
                    di_s[15:8], di_s[7:0]};
    end
  end

  logic [FW-1:0] out_frame;

  cep_fifo #(
    .WIDTH (FW),
    .DEPTH (cep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .in_data   (push_frame),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (out_frame)
  );

  assign tx_ext  = out_frame[97];
  assign tx_id   = out_frame[96:68];
  assign tx_dlc  = out_frame[67:64];
  assign tx_data = out_frame[63:0];

  // error register mirror and history
  logic [7:0]  err_reg_ff;
  logic [31:0] hist_ff [cep_pkg::HIST_DEPTH];
  logic [2:0]  hist_cnt_ff;
  logic [31:0] hist_entry;

  assign hist_entry = {8'h00, ev_mfr, ev_code};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg_ff <= 8'h00;
    end else if (emcy_commit) begin
      err_reg_ff <= ev_reg;
    end
  end

  // an entry landing with a clear wins over it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_cnt_ff <= 3'h0;
    end else if (emcy_commit) begin
      hist_cnt_ff <= hist_clr ? 3'h1 :
                     (hist_cnt_ff == cep_pkg::HIST_MAX) ? hist_cnt_ff :
                     hist_cnt_ff + 3'h1;
    end else if (hist_clr) begin
      hist_cnt_ff <= 3'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_ff[0] <= 32'h0;
    end else if (emcy_commit) begin
      hist_ff[0] <= hist_entry;
    end
  end

  for (genvar g = 1; g < cep_pkg::HIST_DEPTH; g++) begin : g_hist
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        hist_ff[g] <= 32'h0;
      end else if (emcy_commit) begin
        hist_ff[g] <= hist_ff[g-1];
      end
    end
  end

  // object access answer one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      obj_ack   <= 1'b0;
      obj_abort <= 1'b0;
      obj_rdata <= 32'h0;
    end else begin
      obj_ack   <= obj_req;
      obj_abort <= 1'b0;
      obj_rdata <= 32'h0;
      if (obj_req && obj_we) begin
        obj_abort <= !((acc_id && id_wr_ok && init_done_ff) || hist_clr);
      end else if (obj_req) begin
        if (acc_id) begin
          obj_rdata <= cob_id_ff;
        end else if (acc_reg) begin
          obj_rdata <= {24'h0, err_reg_ff};
        end else if (acc_hist && obj_subindex == 8'h00) begin
          obj_rdata <= {29'h0, hist_cnt_ff};
        end else if (acc_hist) begin
          obj_rdata <= 8'(obj_subindex) <= 8'(hist_cnt_ff) ?
                       hist_ff[3'(obj_subindex - 8'h01)] : 32'h0;
        end else begin
          obj_abort <= 1'b1;
        end
      end
    end
  end

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    !cob_id_ff[cep_pkg::COBID_RSVD_BIT])
    else $error("identifier bit 30 set");

  AST_BASE_UPPER_ZERO: assert property (@(posedge clk)
    disable iff (!rst_n)
    !cob_id_ff[cep_pkg::COBID_EXT_BIT] |-> cob_id_ff[28:11] == 18'h0)
    else $error("upper id bits set in base format");

  AST_DEFAULT_ID: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(init_done_ff) |-> cob_id_ff == {21'h0, 4'h1, node_s})
    else $error("default identifier wrong");

  AST_SUPPRESS: assert property (@(posedge clk) disable iff (!rst_n)
    (emcy_commit && emcy_off) |-> !fifo_push ##1
      hist_ff[0] == $past(hist_entry))
    else $error("emergency sent while disabled or not recorded");

  AST_HIST_SHIFT: assert property (@(posedge clk) disable iff (!rst_n)
    emcy_commit |=> hist_ff[4] == $past(hist_ff[3]) &&
                    hist_ff[1] == $past(hist_ff[0]))
    else $error("history did not shift");

  AST_MIRROR: assert property (@(posedge clk) disable iff (!rst_n)
    emcy_commit |=> err_reg_ff == $past(ev_reg) && !err_reg_ff[6])
    else $error("error register mirror not updated");

  AST_PAYLOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (fifo_push && emcy_pend_ff) |-> push_frame[7:0] == ev_code[7:0] &&
      push_frame[15:8] == ev_code[15:8] && push_frame[23:16] == ev_reg &&
      push_frame[31:24] == ev_mfr && push_frame[67:64] == 4'h8)
    else $error("emergency payload layout wrong");

  AST_PDO_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    (emcy_pend_ff && emcy_kind_ff == 4'h9) |-> hist_entry == 32'h00098210)
    else $error("pdo length error coding wrong");

  AST_TPDO_TRIG: assert property (@(posedge clk) disable iff (!rst_n)
    di_change |=> tp1_pend_ff && tp5_pend_ff)
    else $error("input change did not request pdos");

  AST_LSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    sel_tp1 |-> push_frame[7:0] == di_s[7:0] && push_frame[15:8] == di_s[15:8])
    else $error("pdo value not low byte first");

  AST_HIST_CAP: assert property (@(posedge clk) disable iff (!rst_n)
    (emcy_commit && !hist_clr && hist_cnt_ff == 3'h5) |=> hist_cnt_ff == 3'h5)
    else $error("history count exceeded five");

endmodule : cep_emcy_producer
`default_nettype wire

// ---- bench/cep_consumer.sv ----
// far-side frame consumer model with commanded stall
`timescale 1ns/1ps
`default_nettype none
module cep_consumer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        stall,
  input  wire logic        tx_valid,
  output var  logic        tx_ready,
  input  wire logic        tx_ext,
  input  wire logic [28:0] tx_id,
  input  wire logic [3:0]  tx_dlc,
  input  wire logic [63:0] tx_data
);
  logic [97:0] rx_q[$];

  // never ready in reset or while told to stall
  assign tx_ready = rst_n & ~stall;

  // frame taken only at an accepting edge and queued whole as ext, id, dlc and data
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      rx_q.push_back({tx_ext, tx_id, tx_dlc, tx_data});
    end
  end
endmodule : cep_consumer
`default_nettype wire

// ---- bench/cep_emcy_producer_test.sv ----
// self-checking bench for the emergency producer
`timescale 1ns/1ps
`default_nettype none
module cep_emcy_producer_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        stall = 1'b0;
  logic [15:0] digital_input_word = 16'h0000;
  logic [15:0] analog_input_channel = 16'hFFFF;
  logic        err_valid = 1'b0;
  logic [3:0]  err_kind = 4'h0;
  logic        err_busy;
  logic        obj_req = 1'b0;
  logic        obj_we = 1'b0;
  logic [15:0] obj_index = 16'h0000;
  logic [7:0]  obj_subindex = 8'h00;
  logic [31:0] obj_wdata = 32'h0000_0000;
  logic        obj_ack;
  logic        obj_abort;
  logic [31:0] obj_rdata;
  logic        tx_valid;
  logic        tx_ready;
  logic        tx_ext;
  logic [28:0] tx_id;
  logic [3:0]  tx_dlc;
  logic [63:0] tx_data;
  int          n_errors = 0;
  int          checks = 0;

  // code, register, first vendor byte for kinds 0..A
  localparam logic [31:0] ROWS [11] = '{
    32'h0000_0000, 32'h1000_8101, 32'h5000_8102, 32'h5000_8103,
    32'h8110_1104, 32'h8110_1105, 32'h8110_1106, 32'h8130_1107,
    32'h8140_1108, 32'h8210_1109, 32'hFF00_800A};

  always #5 clk = ~clk;

  cep_emcy_producer cep_emcy_producer_inst (
    .clk(clk), .rst_n(rst_n), .node_id(7'h01),
    .digital_input_word(digital_input_word),
    .analog_input_channel(analog_input_channel),
    .err_valid(err_valid), .err_kind(err_kind), .err_busy(err_busy),
    .obj_req(obj_req), .obj_we(obj_we), .obj_index(obj_index),
    .obj_subindex(obj_subindex), .obj_wdata(obj_wdata),
    .obj_ack(obj_ack), .obj_abort(obj_abort), .obj_rdata(obj_rdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_ext(tx_ext),
    .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data));

  cep_consumer cep_consumer_inst (
    .clk(clk), .rst_n(rst_n), .stall(stall), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_ext(tx_ext), .tx_id(tx_id),
    .tx_dlc(tx_dlc), .tx_data(tx_data));

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [97:0] got, input logic [97:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic timed_out();
    n_errors++;
    $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
    close_out();
  endtask : timed_out

  function automatic logic [97:0] emcy(input logic e, input logic [28:0] id,
                                       input logic [31:0] r);
    return {e, id, 4'h8, 32'h0, r[7:0], r[15:8], r[31:24], r[23:16]};
  endfunction : emcy

  // one object access, answer sampled in its single valid cycle
  task automatic acc(input logic we, input logic [15:0] idx,
                     input logic [7:0] sub, input logic [31:0] wd,
                     input logic ab, input logic [31:0] exp_d);
    @(posedge clk);
    obj_req      <= 1'b1;
    obj_we       <= we;
    obj_index    <= idx;
    obj_subindex <= sub;
    obj_wdata    <= wd;
    @(posedge clk);
    obj_req <= 1'b0;
    #1;
    chk({obj_ack, obj_abort, obj_rdata}, {1'b1, ab, exp_d});
  endtask : acc

  // idle: wait until the producer can take an event
  task automatic send_err(input logic [3:0] k, input logic idle);
    int n;
    @(posedge clk);
    #1;
    for (n = 0; idle && err_busy !== 1'b0; n++) begin
      if (n > 300) timed_out();
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    err_valid <= 1'b1;
    err_kind  <= k;
    @(posedge clk);
    err_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : send_err

  task automatic get_frame(input logic [97:0] exp);
    int n;
    for (n = 0; cep_consumer_inst.rx_q.size() == 0; n++) begin
      if (n > 300) timed_out();
      @(posedge clk);
    end
    chk(cep_consumer_inst.rx_q.pop_front(), exp);
  endtask : get_frame

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({tx_valid, obj_ack, err_busy}, 98'h0);
    repeat (4) @(posedge clk);
    acc(1'b0, 16'h1014, 8'h00, 32'h0, 1'b0, 32'h0000_0081);
    // input change fires both mapped transmit pdos
    @(posedge clk);
    digital_input_word <= 16'h90AB;
    get_frame({1'b0, 29'h181, 4'h2, 64'h90AB});
    get_frame({1'b0, 29'h185, 4'h4, 64'hFFFF_90AB});
    for (int i = 0; i < 11; i++) begin
      send_err(i[3:0], 1'b1);
      get_frame(emcy(1'b0, 29'h81, ROWS[i]));
      acc(1'b0, 16'h1001, 8'h00, 32'h0, 1'b0,
          {24'h0, ROWS[i][15:8]});
      acc(1'b0, 16'h1003, 8'h01, 32'h0, 1'b0,
          {8'h0, ROWS[i][7:0], ROWS[i][31:16]});
    end
    acc(1'b0, 16'h1003, 8'h00, 32'h0, 1'b0, 32'h5);
    acc(1'b0, 16'h1003, 8'h05, 32'h0, 1'b0, 32'h0006_8110);
    acc(1'b0, 16'h1003, 8'h04, 32'h0, 1'b0, 32'h0007_8130);
    acc(1'b0, 16'h1003, 8'h06, 32'h0, 1'b1, 32'h0);
    // refused writes
    acc(1'b1, 16'h1001, 8'h00, 32'h11, 1'b1, 32'h0);
    acc(1'b1, 16'h1014, 8'h00, 32'h0000_0881, 1'b1, 32'h0);
    acc(1'b1, 16'h2000, 8'h00, 32'h0, 1'b1, 32'h0);
    acc(1'b1, 16'h1003, 8'h00, 32'h1, 1'b1, 32'h0);
    // extended identifier with the reserved bit set
    acc(1'b1, 16'h1014, 8'h00, 32'h7123_4567, 1'b0, 32'h0);
    acc(1'b0, 16'h1014, 8'h00, 32'h0, 1'b0, 32'h3123_4567);
    send_err(4'h9, 1'b1);
    get_frame(emcy(1'b1, 29'h1123_4567, ROWS[9]));
    // service absent: nothing sent, history still kept
    acc(1'b1, 16'h1014, 8'h00, 32'h8000_0081, 1'b0, 32'h0);
    send_err(4'h1, 1'b1);
    repeat (30) @(posedge clk);
    chk(cep_consumer_inst.rx_q.size(), 98'h0);
    acc(1'b0, 16'h1003, 8'h01, 32'h0, 1'b0, 32'h0001_1000);
    acc(1'b1, 16'h1003, 8'h00, 32'h0, 1'b0, 32'h0);
    acc(1'b0, 16'h1003, 8'h00, 32'h0, 1'b0, 32'h0);
    acc(1'b0, 16'h1003, 8'h01, 32'h0, 1'b0, 32'h0);
    // stalled consumer: buffer fills, producer holds the pending event
    acc(1'b1, 16'h1014, 8'h00, 32'h0000_0081, 1'b0, 32'h0);
    @(posedge clk);
    stall <= 1'b1;
    for (int k = 1; k < 8; k++) send_err(k[3:0], 1'b0);
    #1;
    chk({tx_valid, err_busy}, 98'h3);
    @(posedge clk);
    stall <= 1'b0;
    for (int k = 1; k < 7; k++) begin
      get_frame(emcy(1'b0, 29'h81, ROWS[k]));
    end
    repeat (60) @(posedge clk);
    #1;
    chk({tx_valid, err_busy}, 98'h0);
    chk(cep_consumer_inst.rx_q.size(), 98'h0);
    close_out();
  end
endmodule : cep_emcy_producer_test
`default_nettype wire
